// >>> core/oepc_cfg.svh
// register offsets, field positions and reset values for output enable
// assumes a 9-bit register port with word addresses as printed
`ifndef OEPC_CFG_SVH
`define OEPC_CFG_SVH
`define OEPC_ADDR_W 7
`define OEPC_DATA_W 9
`define OEPC_OFF_PWR1 7'h01
`define OEPC_OFF_PWR2 7'h02
`define OEPC_OFF_PWR3 7'h03
`define OEPC_OFF_OUT1 7'h2a
`define OEPC_OFF_OUTC 7'h31
`define OEPC_OFF_DPOL 7'h0a
`define OEPC_OFF_ISTAT 7'h10
`define OEPC_OFF_IMASK 7'h11
`define OEPC_RST_REG 9'h000
`define OEPC_P1_TIEOFF 2
`define OEPC_P1_AUXL_MIX 6
`define OEPC_P1_AUXR_MIX 7
`define OEPC_P1_LVLSHIFT 8
`define OEPC_P2_STANDBY 6
`define OEPC_P2_HP_LEFT 7
`define OEPC_P2_HP_RIGHT 8
`define OEPC_P3_MAIN_LMIX 2
`define OEPC_P3_MAIN_RMIX 3
`define OEPC_P3_SPK_RIGHT 5
`define OEPC_P3_SPK_LEFT 6
`define OEPC_P3_AUX_LEFT 7
`define OEPC_P3_AUX_RIGHT 8
`define OEPC_O1_TWO_STAGE 0
`define OEPC_O1_DELAYED 1
`define OEPC_OC_TSD_EN 1
`define OEPC_OC_AUXL_BOOST 3
`define OEPC_OC_AUXR_BOOST 4
`define OEPC_OC_SPK_BOOST 2
`define OEPC_OC_SPKR_INV 5
`define OEPC_DP_LEFT_INV 0
`define OEPC_DP_RIGHT_INV 1
`define OEPC_MX_LDAC_AUXL 2
`define OEPC_MX_LMIX_AUXL 3
`define OEPC_MX_RDAC_AUXR 4
`define OEPC_MX_RMIX_AUXR 5
`define OEPC_IS_OVERTEMP 0
`define OEPC_IS_SHUTDOWN 1
`endif

// >>> core/oepc_pkg.sv
// types for the output enable and phase control block
// assumes oepc_cfg.svh supplies the widths
`include "oepc_cfg.svh"
package oepc_pkg;
	// analogue stage enables as driven to the output stages
	typedef struct packed {
		logic tieoff_bias_buffer_enable;
		logic aux_left_mixer_enable;
		logic aux_right_mixer_enable;
		logic level_shift_driver_enable;
		logic headphone_left_enable;
		logic headphone_right_enable;
		logic headphone_delayed_enable;
		logic main_left_mixer_enable;
		logic main_right_mixer_enable;
		logic speaker_left_enable;
		logic speaker_right_enable;
		logic aux_left_enable;
		logic aux_right_enable;
		logic standby;
	} oepc_enables_t;
	// phase of each output: 1 means inverted against the left dac input
	typedef struct packed {
		logic headphone_left_pin;
		logic headphone_right_pin;
		logic speaker_left_pin;
		logic speaker_right_pin;
		logic aux_left_pin;
		logic aux_right_pin;
	} oepc_phase_t;
	// register port request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [`OEPC_ADDR_W-1:0] addr;
		logic [`OEPC_DATA_W-1:0] wdata;
	} oepc_req_t;
endpackage

// >>> core/oepc_top.sv
// output enable, phase and thermal gating register bank
// assumes a synchronous register port and an async over-temp level
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "oepc_cfg.svh"
// Summary of operation
// - dac invert bit flips sample sign
// - boost: no inversion; no boost: inverted
// - mixer route adds one inversion
// - each output and mixer own enable
// - all output enables clear after reset except headphone_delayed_enable, which sets
// - enables active high
// - power one bits 2,6,7
// - power one bit 8 level shifter
// - power two bits 8,7,6
// - output control one bits 0,1
// - thermal shutdown disables speaker amplifiers
// - thermal shutdown can raise interrupt
// - output control bit 1 shutdown enable
module oepc_top #(
	parameter int SAMPLE_W = 16
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire oepc_pkg::oepc_req_t req_i,
	output logic [`OEPC_DATA_W-1:0] rdata_o,
	input wire logic overtemp_i,
	input wire logic [SAMPLE_W-1:0] left_dac_signal_i,
	input wire logic [SAMPLE_W-1:0] right_dac_signal_i,
	output logic [SAMPLE_W-1:0] left_dac_signal_o,
	output logic [SAMPLE_W-1:0] right_dac_signal_o,
	output oepc_pkg::oepc_enables_t enables_o,
	output oepc_pkg::oepc_phase_t phase_o,
	output logic irq_o
);
	import oepc_pkg::*;

	localparam int DW = `OEPC_DATA_W;

	// control registers, all nine bits wide
	logic [DW-1:0] power_control_one;
	logic [DW-1:0] power_control_two;
	logic [DW-1:0] power_control_three;
	logic [DW-1:0] output_control_one;
	logic [DW-1:0] output_control;
	logic [DW-1:0] dac_polarity; // dac invert bits plus mixer routing
	logic [DW-1:0] irq_status; // sticky events
	logic [DW-1:0] irq_mask; // one enables the event onto irq_o

	// synchroniser and event detection
	logic ot_meta; // first stage, read only by ot_sync
	logic ot_sync;
	logic ot_prev;
	logic shutdown; // thermal gating active
	logic shutdown_prev;
	logic [DW-1:0] event_set;
	logic [DW-1:0] next_rdata;

	// write strobes per register
	logic wr_p1, wr_p2, wr_p3, wr_o1, wr_oc, wr_dp, wr_is, wr_im;

	// address decode for writes
	always_comb begin
		wr_p1 = req_i.wr && req_i.addr == `OEPC_OFF_PWR1;
		wr_p2 = req_i.wr && req_i.addr == `OEPC_OFF_PWR2;
		wr_p3 = req_i.wr && req_i.addr == `OEPC_OFF_PWR3;
		wr_o1 = req_i.wr && req_i.addr == `OEPC_OFF_OUT1;
		wr_oc = req_i.wr && req_i.addr == `OEPC_OFF_OUTC;
		wr_dp = req_i.wr && req_i.addr == `OEPC_OFF_DPOL;
		wr_is = req_i.wr && req_i.addr == `OEPC_OFF_ISTAT;
		wr_im = req_i.wr && req_i.addr == `OEPC_OFF_IMASK;
	end

	// control register storage
	// reset clears enables
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			power_control_one <= `OEPC_RST_REG;
			power_control_two <= `OEPC_RST_REG;
			power_control_three <= `OEPC_RST_REG;
			output_control_one <= `OEPC_RST_REG;
			output_control <= `OEPC_RST_REG;
			dac_polarity <= `OEPC_RST_REG;
			irq_mask <= `OEPC_RST_REG;
		end else begin
			// one strobe per cycle, so at most one branch fires
			if (wr_p1) begin
				power_control_one <= req_i.wdata;
			end
			if (wr_p2) begin
				power_control_two <= req_i.wdata;
			end
			if (wr_p3) begin
				power_control_three <= req_i.wdata;
			end
			if (wr_o1) begin
				output_control_one <= req_i.wdata;
			end
			if (wr_oc) begin
				output_control <= req_i.wdata;
			end
			if (wr_dp) begin
				dac_polarity <= req_i.wdata;
			end
			if (wr_im) begin
				irq_mask <= req_i.wdata;
			end
		end
	end

	// over-temp level crossing into the system clock
	// two flop synchroniser
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			ot_meta <= 1'b0;
			ot_sync <= 1'b0;
		end else begin
			ot_meta <= overtemp_i;
			ot_sync <= ot_meta;
		end
	end

	// gating term, only while shutdown is enabled
	// gate on over-temp
	always_comb begin
		shutdown = ot_sync && output_control[`OEPC_OC_TSD_EN];
	end

	// rising edges of over-temp and of shutdown become events
	// shutdown event
	always_comb begin
		event_set = '0;
		event_set[`OEPC_IS_OVERTEMP] = ot_sync && !ot_prev;
		event_set[`OEPC_IS_SHUTDOWN] = shutdown && !shutdown_prev;
	end

	// edge history for event detection
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			ot_prev <= 1'b0;
			shutdown_prev <= 1'b0;
		end else begin
			ot_prev <= ot_sync;
			shutdown_prev <= shutdown;
		end
	end

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			irq_status <= `OEPC_RST_REG;
		end else if (wr_is) begin
			irq_status <= (irq_status & ~req_i.wdata) | event_set;
		end else begin
			irq_status <= irq_status | event_set;
		end
	end

	// level interrupt, registered so it lags status by one cycle
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(irq_status & irq_mask);
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		case (req_i.addr)
			`OEPC_OFF_PWR1: next_rdata = power_control_one;
			`OEPC_OFF_PWR2: next_rdata = power_control_two;
			`OEPC_OFF_PWR3: next_rdata = power_control_three;
			`OEPC_OFF_OUT1: next_rdata = output_control_one;
			`OEPC_OFF_OUTC: next_rdata = output_control;
			`OEPC_OFF_DPOL: next_rdata = dac_polarity;
			`OEPC_OFF_ISTAT: next_rdata = irq_status;
			`OEPC_OFF_IMASK: next_rdata = irq_mask;
			default: next_rdata = '0;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			rdata_o <= '0;
		end else if (req_i.rd) begin
			rdata_o <= next_rdata;
		end else begin
			rdata_o <= '0;
		end
	end

	// enables straight from register bits, speakers gated thermally
	// independent enables
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			enables_o <= '0;
		end else begin
			enables_o.tieoff_bias_buffer_enable <=
				power_control_one[`OEPC_P1_TIEOFF];
			enables_o.aux_left_mixer_enable <=
				power_control_one[`OEPC_P1_AUXL_MIX];
			enables_o.aux_right_mixer_enable <=
				power_control_one[`OEPC_P1_AUXR_MIX];
			enables_o.level_shift_driver_enable <=
				power_control_one[`OEPC_P1_LVLSHIFT];
			enables_o.headphone_left_enable <=
				power_control_two[`OEPC_P2_HP_LEFT];
			enables_o.headphone_right_enable <=
				power_control_two[`OEPC_P2_HP_RIGHT];
			enables_o.standby <= power_control_two[`OEPC_P2_STANDBY];
			// delayed second enable
			// second stage only acts when two-stage mode is selected
			enables_o.headphone_delayed_enable <=
				output_control_one[`OEPC_O1_TWO_STAGE] ?
				output_control_one[`OEPC_O1_DELAYED] : 1'b1;
			enables_o.main_left_mixer_enable <=
				power_control_three[`OEPC_P3_MAIN_LMIX];
			enables_o.main_right_mixer_enable <=
				power_control_three[`OEPC_P3_MAIN_RMIX];
			enables_o.speaker_left_enable <=
				power_control_three[`OEPC_P3_SPK_LEFT] && !shutdown;
			enables_o.speaker_right_enable <=
				power_control_three[`OEPC_P3_SPK_RIGHT] && !shutdown;
			enables_o.aux_left_enable <=
				power_control_three[`OEPC_P3_AUX_LEFT];
			enables_o.aux_right_enable <=
				power_control_three[`OEPC_P3_AUX_RIGHT];
		end
	end

	// dac sample sign handling; two's complement negation wraps at min
	// dac invert
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			left_dac_signal_o <= '0;
			right_dac_signal_o <= '0;
		end else begin
			left_dac_signal_o <= dac_polarity[`OEPC_DP_LEFT_INV] ?
				SAMPLE_W'(-left_dac_signal_i) : left_dac_signal_i;
			right_dac_signal_o <= dac_polarity[`OEPC_DP_RIGHT_INV] ?
				SAMPLE_W'(-right_dac_signal_i) : right_dac_signal_i;
		end
	end

	// phase of each pin relative to an uninverted left dac
	logic inv_l, inv_r, mix_l, mix_r;
	logic aux_l_src, aux_r_src;
	always_comb begin
		inv_l = dac_polarity[`OEPC_DP_LEFT_INV];
		inv_r = dac_polarity[`OEPC_DP_RIGHT_INV];
		// main mixer inverts; headphone stage inverts back
		mix_l = !inv_l;
		mix_r = !inv_r;
		// mixer route adds inversion
		// direct dac gives inverted aux mixer output, via main mixer not
		aux_l_src = dac_polarity[`OEPC_MX_LMIX_AUXL] ? !mix_l : mix_l;
		aux_r_src = dac_polarity[`OEPC_MX_RMIX_AUXR] ? !mix_r : mix_r;
	end

	// registered phase report
	// boost sets stage inversion
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			phase_o <= '0;
		end else begin
			phase_o.headphone_left_pin <= inv_l;
			phase_o.headphone_right_pin <= inv_r;
			// speaker stage inverts unless boosted
			phase_o.speaker_left_pin <= inv_l ^
				!output_control[`OEPC_OC_SPK_BOOST];
			phase_o.speaker_right_pin <= inv_r ^
				!output_control[`OEPC_OC_SPK_BOOST] ^
				output_control[`OEPC_OC_SPKR_INV];
			// aux stage: inverting by default, boost removes it
			phase_o.aux_left_pin <= aux_l_src ^
				!output_control[`OEPC_OC_AUXL_BOOST];
			phase_o.aux_right_pin <= aux_r_src ^
				!output_control[`OEPC_OC_AUXR_BOOST];
		end
	end
endmodule // oepc_top

// >>> bench/oepc_top_sva.sv
// port checks for the output enable and phase bank
// assumes one clock and a synchronous active low reset
`timescale 1ns/1ps
module oepc_sva #(
	parameter int SAMPLE_W = 16
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire oepc_pkg::oepc_req_t req_i,
	input wire logic [8:0] rdata_o,
	input wire logic overtemp_i,
	input wire logic [SAMPLE_W-1:0] left_dac_signal_i,
	input wire logic [SAMPLE_W-1:0] right_dac_signal_i,
	input wire logic [SAMPLE_W-1:0] left_dac_signal_o,
	input wire logic [SAMPLE_W-1:0] right_dac_signal_o,
	input wire oepc_pkg::oepc_enables_t enables_o,
	input wire oepc_pkg::oepc_phase_t phase_o,
	input wire logic irq_o
);
	import oepc_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	// read data only in the cycle after a read
	AST_RDATA_IDLE:
		assert property (!req_i.rd |=> rdata_o == 9'h000)
		else $error("read data outside read cycle");
	AST_UNMAPPED:
		assert property (req_i.rd && req_i.addr == 7'h05 |=> rdata_o == 0)
		else $error("unmapped read not zero");
	// samples pass or are negated, one cycle late
	AST_DAC_L:
		assert property (1'b1 |=> left_dac_signal_o == $past(left_dac_signal_i)
			|| left_dac_signal_o + $past(left_dac_signal_i) == '0)
		else $error("left sample mangled");
	AST_DAC_R:
		assert property (1'b1 |=> right_dac_signal_o == $past(right_dac_signal_i)
			|| right_dac_signal_o + $past(right_dac_signal_i) == '0)
		else $error("right sample mangled");
	// speaker drops only by a write or over-temp
	AST_SPK_FALL:
		assert property ($fell(enables_o.speaker_left_enable)
			|-> $past(req_i.wr, 2) || $past(overtemp_i, 3))
		else $error("speaker dropped without cause");
	AST_IRQ_RISE:
		assert property ($rose(irq_o) |-> $past(req_i.wr, 2) || $past(overtemp_i, 4))
		else $error("irq rose without cause");
	AST_IRQ_FALL:
		assert property ($fell(irq_o) |-> $past(req_i.wr, 2))
		else $error("irq fell without write");
	// two flops sit before the gating
	AST_SYNC:
		assert property ($rose(overtemp_i) && enables_o.speaker_left_enable
			|=> enables_o.speaker_left_enable [*2])
		else $error("over-temp not synchronised");
	AST_PHASE_HOLD:
		assert property (!req_i.wr [*4] |-> $stable(phase_o))
		else $error("phase changed without write");
	cover property (req_i.wr && req_i.addr == 7'h31);
	cover property ($rose(irq_o));
	cover property ($fell(enables_o.speaker_left_enable));
endmodule // oepc_sva
bind oepc_top oepc_sva #(.SAMPLE_W(SAMPLE_W)) oepc_sva_inst (
	.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_i(req_i),
	.rdata_o(rdata_o), .overtemp_i(overtemp_i),
	.left_dac_signal_i(left_dac_signal_i), .right_dac_signal_i(right_dac_signal_i),
	.left_dac_signal_o(left_dac_signal_o), .right_dac_signal_o(right_dac_signal_o),
	.enables_o(enables_o), .phase_o(phase_o), .irq_o(irq_o));

// >>> bench/oepc_tb_top.sv
// register-port bench for the output enable and phase bank
// assumes the bank answers reads one cycle later
`timescale 1ns/1ps
module output_enable_phase_control_tb_top;
	import oepc_pkg::*;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic ot = 1'b0;
	oepc_req_t req = '0;
	logic [15:0] l_in = 16'h1234;
	logic [15:0] r_in = 16'h0ff0;
	logic [8:0] rdata;
	logic [15:0] l_out;
	logic [15:0] r_out;
	oepc_enables_t en;
	oepc_phase_t ph;
	logic irq;
	logic [6:0] ad [5] = '{7'h01, 7'h02, 7'h03, 7'h2a, 7'h31};
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	oepc_top oepc_top_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.req_i(req), .rdata_o(rdata), .overtemp_i(ot),
		.left_dac_signal_i(l_in), .right_dac_signal_i(r_in),
		.left_dac_signal_o(l_out), .right_dac_signal_o(r_out),
		.enables_o(en), .phase_o(ph), .irq_o(irq));
	initial begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end
	task automatic conclude;
		if (n_errors == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// hang guard, the run needs well under 1000 cycles
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			$display("unexpected %0t timeout", $time);
			conclude();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one-cycle write, then wait until outputs follow
	task automatic wr(input logic [6:0] a, input logic [8:0] d);
		@(posedge clk_sys_i);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge clk_sys_i);
		req.wr <= 1'b0;
		repeat (2) @(negedge clk_sys_i);
	endtask
	// read data stand only in the following cycle
	task automatic rd(input logic [6:0] a, input logic [8:0] e);
		@(posedge clk_sys_i);
		req <= '{1'b0, 1'b1, a, 9'h000};
		@(posedge clk_sys_i);
		req.rd <= 1'b0;
		@(negedge clk_sys_i);
		chk(rdata, e);
	endtask
	// one enable bit set alone, then cleared
	task automatic wen(input logic [6:0] a, input logic [8:0] d,
		input logic [13:0] e);
		wr(a, d);
		chk(en, e);
		wr(a, 9'h000);
	endtask
	task automatic pchk(input logic [8:0] d, input logic [5:0] e);
		wr(7'h31, d);
		chk(ph, e);
	endtask
	initial begin
		repeat (10) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		repeat (3) @(negedge clk_sys_i);
		chk(en, 14'h0080);
		foreach (ad[i]) begin
			rd(ad[i], 9'h000);
			wr(ad[i], 9'h1ff);
			rd(ad[i], 9'h1ff);
			wr(ad[i], 9'h000);
		end
		wr(7'h05, 9'h1ff);
		rd(7'h05, 9'h000);
		wen(7'h01, 9'h004, 14'h2080);
		wen(7'h01, 9'h040, 14'h1080);
		wen(7'h01, 9'h080, 14'h0880);
		wen(7'h01, 9'h100, 14'h0480);
		wen(7'h02, 9'h100, 14'h0180);
		wen(7'h02, 9'h080, 14'h0280);
		wen(7'h02, 9'h040, 14'h0081);
		wen(7'h03, 9'h004, 14'h00c0);
		wen(7'h03, 9'h008, 14'h00a0);
		wen(7'h03, 9'h020, 14'h0088);
		wen(7'h03, 9'h040, 14'h0090);
		wen(7'h03, 9'h080, 14'h0084);
		wen(7'h03, 9'h100, 14'h0082);
		// two-stage headphone power-up
		wen(7'h2a, 9'h001, 14'h0000);
		wen(7'h2a, 9'h003, 14'h0080);
		pchk(9'h000, 6'h0c);
		pchk(9'h004, 6'h00);
		pchk(9'h018, 6'h0f);
		pchk(9'h020, 6'h08);
		pchk(9'h024, 6'h04);
		pchk(9'h03c, 6'h07);
		wr(7'h31, 9'h000);
		wr(7'h0a, 9'h001);
		chk(ph, 6'h26);
		chk(l_out, 16'hedcc);
		chk(r_out, 16'h0ff0);
		wr(7'h0a, 9'h028);
		chk(ph, 6'h0f);
		wr(7'h0a, 9'h000);
		// shutdown enabled, interrupt masked at first
		wr(7'h01, 9'h004);
		wr(7'h03, 9'h060);
		wr(7'h31, 9'h002);
		@(posedge clk_sys_i);
		ot <= 1'b1;
		repeat (6) @(negedge clk_sys_i);
		chk(en.speaker_left_enable | en.speaker_right_enable, 0);
		chk(irq, 0);
		rd(7'h10, 9'h003);
		wr(7'h11, 9'h003);
		chk(irq, 1);
		@(posedge clk_sys_i);
		ot <= 1'b0;
		repeat (4) @(negedge clk_sys_i);
		wr(7'h10, 9'h003);
		@(negedge clk_sys_i);
		chk(irq, 0);
		chk(en, 14'h2098);
		// shutdown disabled: speakers stay on
		wr(7'h31, 9'h000);
		@(posedge clk_sys_i);
		ot <= 1'b1;
		repeat (6) @(negedge clk_sys_i);
		chk(en, 14'h2098);
		conclude();
	end
endmodule // output_enable_phase_control_tb_top
